// >>> design/cbd_alu.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// (RULE1) Accumulator complement inverts each bit, sets negative and zero.
// (RULE2) Bit complement inverts the carry flag or an addressable bit.
// (RULE3) A port operand is read from its output latch, never the pins.
// (RULE4) Bit complement changes flags only when the operand is carry.
// (RULE5) Extended bit complement is escaped in binary mode only.
// (RULE6) Low nibble above nine or aux carry adds 06h; carry is never cleared.
// (RULE7) Then carry or high nibble above nine adds 60h; carry out sets carry.
// (RULE8) Decimal adjust adds 00h/06h/60h/66h in one cycle, keeps overflow.
// (RULE9) Decimal adjust is one unescaped opcode byte in both modes.
// (RULE10) Byte decrement subtracts one, zero wrapping to all ones, no carry.
// (RULE11) Byte decrement updates only negative and zero.
// (RULE12) Byte decrement works on accumulator, direct, indirect and registers.
// (RULE13) Indirect and register decrement are escaped in source mode only.
// (RULE14) Short decrement takes 1, 2 or 4 off a register, sets negative/zero.
// (RULE15) Short decrement is one opcode, escaped in binary mode only.
// (RULE16) The short field maps 0, 1, 2 to 1, 2, 4 and reserves code 3.
// (RULE17) Negative takes the result's top bit; zero marks an all-zero result.
module cbd_alu
  import cbd_alu_pkg::*;
#(
  parameter int DATA_W = 32  // Widest register operand
) (
  input wire logic sys_clk_i,  // Core clock, 10 MHz
  input wire logic sys_rst_i,  // Async reset, active high
  input wire logic clk_en_i,  // Freezes all state while low
  input wire logic exec_i,  // Execute the presented instruction
  input wire logic source_mode_i,  // High: source mode, low: binary
  input wire instr_t instr_i,  // Prefix flag, opcode, second byte
  input wire logic short_wide_i,  // Byte/word field picks word register
  input wire logic [7:0] acc_i,  // Accumulator value
  input wire logic [7:0] mem_byte_i,  // Direct/indirect/register byte
  input wire logic mem_is_port_i,  // Byte operand is an output port
  input wire logic [7:0] port_latch_i,  // Port output latch contents
  input wire logic bit_val_i,  // Addressed bit (memory side)
  input wire logic bit_is_port_i,  // Addressed bit is a port pin
  input wire logic bit_latch_i,  // Port latch bit for that pin
  input wire logic [DATA_W-1:0] reg_val_i,  // Register file operand
  input wire flags_t flags_i,  // Current status flags
  output flags_t flags_o,  // Updated status flags
  output logic [DATA_W-1:0] result_o,  // Result value
  output logic [2:0] bit_pos_o,  // Bit position of extended form
  output logic [7:0] addr_o,  // Address/register field byte
  output logic wr_acc_o,  // Write result to accumulator
  output logic wr_mem_o,  // Write result byte to memory
  output logic wr_reg_o,  // Write result to register file
  output logic wr_bit_o,  // Write result bit 0 to bit space
  output op_width_t width_o,  // Register width of result
  output logic illegal_o  // Not decoded or reserved field
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic esc_ok_bin;  // Escape present exactly when binary mode needs it
  logic esc_ok_src;  // Escape present exactly when source mode needs it
  logic esc_none;
  logic dec_cpl_acc, dec_cpl_bit, dec_cpl_cy, dec_cpl_ext, dec_da;
  logic dec_dec_acc, dec_dec_dir, dec_dec_ind, dec_dec_reg, dec_dec_short;
  logic [1:0] short_code;

  assign esc_none = !instr_i.escaped;
  assign esc_ok_bin = instr_i.escaped == !source_mode_i;
  assign esc_ok_src = instr_i.escaped == source_mode_i;
  assign short_code = instr_i.operand[1:0];

  // Each form is recognised only with its correct prefix in the mode
  assign dec_cpl_acc = esc_none && instr_i.opcode == OPC_CPL_ACC;  // RULE1
  assign dec_cpl_bit = esc_none && instr_i.opcode == OPC_CPL_BIT;  // RULE2
  assign dec_cpl_cy = esc_none && instr_i.opcode == OPC_CPL_CARRY;  // RULE2
  assign dec_cpl_ext = esc_ok_bin && instr_i.opcode == OPC_EXT_BIT
    && instr_i.operand[7:4] == EXT_CPL_HI
    && !instr_i.operand[BIT_POS_W];  // RULE5
  assign dec_da = esc_none && instr_i.opcode == OPC_DECIMAL_ADJUST;  // RULE9
  assign dec_dec_acc = esc_none && instr_i.opcode == OPC_DEC_ACC;  // RULE12
  assign dec_dec_dir = esc_none && instr_i.opcode == OPC_DEC_DIR;  // RULE12
  assign dec_dec_ind = esc_ok_src
    && instr_i.opcode[7:1] == OPC_DEC_IND;  // RULE13
  assign dec_dec_reg = esc_ok_src
    && instr_i.opcode[7:3] == OPC_DEC_REG;  // RULE13
  assign dec_dec_short = esc_ok_bin && instr_i.opcode == OPC_DEC_SHORT
    && (instr_i.operand[3:2] == SHORT_BW
    || instr_i.operand[3:2] == SHORT_DW);  // RULE15

  ////////////////////////////////////////////////////////////////////////
  // Datapath

  logic [7:0] byte_src;
  logic [7:0] byte_dec;
  logic [7:0] acc_not;
  logic bit_src;
  logic lo_fix, hi_fix;
  logic [8:0] da_lo_sum;
  logic [8:0] da_sum;
  logic [7:0] da_add;
  logic da_carry;
  logic [31:0] short_amt;
  logic short_reserved;
  op_width_t short_width;
  logic [DATA_W-1:0] short_res;

  // Port operands use the output latch, never the pins
  assign byte_src = mem_is_port_i ? port_latch_i : mem_byte_i;  // RULE3
  assign bit_src = bit_is_port_i ? bit_latch_i : bit_val_i;  // RULE3

  assign acc_not = ~acc_i;  // RULE1
  // Plain wrap, no borrow is reported
  assign byte_dec = (dec_dec_acc ? acc_i : byte_src) - 8'h01;  // RULE10

  // Two-step adjust folded into one add of 00h/06h/60h/66h
  assign lo_fix = acc_i[3:0] > BCD_LIMIT || flags_i.aux_carry_flag;  // RULE6
  assign da_lo_sum = {1'b0, acc_i} + {5'h00, lo_fix ? BCD_FIX : 4'h0};
  assign hi_fix = flags_i.carry_flag || da_lo_sum[8]
    || da_lo_sum[7:4] > BCD_LIMIT;  // RULE7
  assign da_add = {hi_fix ? BCD_FIX : 4'h0, lo_fix ? BCD_FIX : 4'h0};  // RULE8
  assign da_sum = {1'b0, acc_i} + {1'b0, da_add};
  // Carry may only be set by the adjust, never cleared
  assign da_carry = flags_i.carry_flag || da_sum[8];  // RULE6 RULE7

  // Short field: 0,1,2 give 1,2,4; 3 is reserved
  always_comb begin
    short_reserved = 1'b0;
    case (short_code)
      2'h0: short_amt = SHORT_AMT_1;  // RULE16
      2'h1: short_amt = SHORT_AMT_2;  // RULE16
      2'h2: short_amt = SHORT_AMT_4;  // RULE16
      default: begin
        short_amt = SHORT_AMT_1;
        short_reserved = 1'b1;  // RULE16
      end
    endcase
  end

  // Width picks how many low bits carry the result
  always_comb begin
    short_res = '0;
    if (instr_i.operand[3:2] == SHORT_DW) begin
      short_width = WIDTH_DWORD;
      short_res = reg_val_i - short_amt[DATA_W-1:0];  // RULE14
    end else if (short_wide_i) begin
      short_width = WIDTH_WORD;
      short_res[15:0] = reg_val_i[15:0] - short_amt[15:0];  // RULE14
    end else begin
      short_width = WIDTH_BYTE;
      short_res[7:0] = reg_val_i[7:0] - short_amt[7:0];  // RULE14
    end
  end

  function automatic logic msb_of(input logic [DATA_W-1:0] v,
                                  input op_width_t w);
    case (w)
      WIDTH_DWORD: msb_of = v[DATA_W-1];
      WIDTH_WORD: msb_of = v[15];
      default: msb_of = v[7];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Result and flag register, one cycle per instruction

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flags_o <= FLAGS_RESET;
      result_o <= '0;
      bit_pos_o <= 3'h0;
      addr_o <= 8'h00;
      wr_acc_o <= 1'b0;
      wr_mem_o <= 1'b0;
      wr_reg_o <= 1'b0;
      wr_bit_o <= 1'b0;
      width_o <= WIDTH_BYTE;
      illegal_o <= 1'b0;
    end else if (clk_en_i) begin
      // Strobes last one cycle unless another instruction follows
      wr_acc_o <= 1'b0;
      wr_mem_o <= 1'b0;
      wr_reg_o <= 1'b0;
      wr_bit_o <= 1'b0;
      illegal_o <= 1'b0;
      if (exec_i) begin
        flags_o <= flags_i;  // Untouched flags pass through
        addr_o <= instr_i.operand;
        bit_pos_o <= instr_i.operand[BIT_POS_W-1:0];
        width_o <= WIDTH_BYTE;
        result_o <= '0;
        if (dec_cpl_acc) begin
          result_o[7:0] <= acc_not;  // RULE1
          flags_o.negative_flag <= acc_not[7];  // RULE17
          flags_o.zero_flag <= acc_not == 8'h00;  // RULE17
          wr_acc_o <= 1'b1;
        end else if (dec_cpl_cy) begin
          flags_o.carry_flag <= !flags_i.carry_flag;  // RULE2 RULE4
        end else if (dec_cpl_bit || dec_cpl_ext) begin
          result_o[0] <= !bit_src;  // RULE2 RULE4
          wr_bit_o <= 1'b1;
        end else if (dec_da) begin
          result_o[7:0] <= da_sum[7:0];  // RULE8
          flags_o.carry_flag <= da_carry;  // RULE6 RULE7
          flags_o.negative_flag <= da_sum[7];  // RULE17
          flags_o.zero_flag <= da_sum[7:0] == 8'h00;  // RULE17
          wr_acc_o <= 1'b1;
        end else if (dec_dec_acc || dec_dec_dir || dec_dec_ind
                     || dec_dec_reg) begin
          result_o[7:0] <= byte_dec;  // RULE10
          flags_o.negative_flag <= byte_dec[7];  // RULE11 RULE17
          flags_o.zero_flag <= byte_dec == 8'h00;  // RULE11 RULE17
          wr_acc_o <= dec_dec_acc;  // RULE12
          wr_mem_o <= !dec_dec_acc;  // RULE12
        end else if (dec_dec_short && !short_reserved) begin
          result_o <= short_res;  // RULE14
          width_o <= short_width;
          flags_o.negative_flag <= msb_of(short_res, short_width);  // RULE17
          flags_o.zero_flag <= short_res == '0;  // RULE14 RULE17
          wr_reg_o <= 1'b1;
        end else begin
          illegal_o <= 1'b1;  // Flags pass through unchanged
        end
      end
    end
  end

endmodule // cbd_alu

`default_nettype wire

// >>> common/cbd_alu_pkg.sv
package cbd_alu_pkg;

  // Opcode bytes (high nibble, low nibble joined)
  localparam logic [7:0] ESCAPE_PREFIX = 8'hA5;
  localparam logic [7:0] OPC_CPL_ACC = 8'hF4;
  localparam logic [7:0] OPC_CPL_BIT = 8'hB2;
  localparam logic [7:0] OPC_CPL_CARRY = 8'hB3;
  localparam logic [7:0] OPC_EXT_BIT = 8'hA9;
  localparam logic [3:0] EXT_CPL_HI = 4'hB;
  localparam logic [7:0] OPC_DECIMAL_ADJUST = 8'hD4;
  localparam logic [7:0] OPC_DEC_ACC = 8'h14;
  localparam logic [7:0] OPC_DEC_DIR = 8'h15;
  localparam logic [6:0] OPC_DEC_IND = 7'h0B;
  localparam logic [4:0] OPC_DEC_REG = 5'h03;
  localparam logic [7:0] OPC_DEC_SHORT = 8'h1B;
  localparam logic [1:0] SHORT_BW = 2'h1;
  localparam logic [1:0] SHORT_DW = 2'h3;
  localparam int BIT_POS_W = 3;

  // Decimal adjust constants
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  // Short immediate amounts
  localparam logic [31:0] SHORT_AMT_1 = 32'h0000_0001;
  localparam logic [31:0] SHORT_AMT_2 = 32'h0000_0002;
  localparam logic [31:0] SHORT_AMT_4 = 32'h0000_0004;

  // Operand width select for the short decrement
  typedef enum logic [1:0] {WIDTH_BYTE, WIDTH_WORD, WIDTH_DWORD} op_width_t;

  // Instruction fetched bytes as presented by the decoder
  typedef struct packed {
    logic escaped;   // Escape prefix seen before the opcode
    logic [7:0] opcode;
    logic [7:0] operand;  // Second byte (bit addr, register fields)
  } instr_t;

  // Flag bundle of the status word
  typedef struct packed {
    logic carry_flag;
    logic aux_carry_flag;
    logic overflow_flag;
    logic negative_flag;
    logic zero_flag;
  } flags_t;

  localparam flags_t FLAGS_RESET = '0;

endpackage

// >>> tb/cbd_alu_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// Result and flag relations seen at the datapath ports
module cbd_alu_monitor
  import cbd_alu_pkg::*;
#(
  parameter int DATA_W = 32  // Register width
) (
  input wire logic sys_clk_i,  // Clock
  input wire logic sys_rst_i,  // Reset
  input wire logic clk_en_i,  // Run enable
  input wire logic exec_i,  // Execute
  input wire instr_t instr_i,  // Instruction
  input wire logic [7:0] acc_i,  // Accumulator
  input wire flags_t flags_i,  // Flags in
  input wire flags_t flags_o,  // Flags out
  input wire logic [DATA_W-1:0] result_o,  // Result
  input wire logic wr_acc_o,  // Acc strobe
  input wire logic wr_bit_o,  // Bit strobe
  input wire logic illegal_o  // Refusal
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Escaped forms are judged through the refusal check only
  wire logic plain = exec_i && clk_en_i && !instr_i.escaped;
  wire logic [7:0] opc = instr_i.opcode;
  ////////////////////////////////////////////////////////////////////////////
  property p_cpl_acc;
    plain && opc == OPC_CPL_ACC |=> wr_acc_o && result_o[7:0] == ~$past(acc_i);
  endproperty
  a_cpl_acc: assert property (p_cpl_acc)
    else $error("accumulator complement wrong");
  property p_cpl_keep;
    plain && opc == OPC_CPL_ACC |=> flags_o[4:2] == $past(flags_i[4:2]);
  endproperty
  a_cpl_keep: assert property (p_cpl_keep)
    else $error("complement touched carry flags");
  property p_nz;
    plain && (opc == OPC_CPL_ACC || opc == OPC_DEC_ACC) |=>
      flags_o[1:0] == {result_o[7], result_o[7:0] == 8'h00};
  endproperty
  a_nz: assert property (p_nz)
    else $error("negative or zero flag wrong");
  property p_da_cy;
    plain && opc == OPC_DECIMAL_ADJUST && flags_i.carry_flag |=>
      flags_o.carry_flag;
  endproperty
  a_da_cy: assert property (p_da_cy)
    else $error("decimal adjust cleared carry");
  property p_da_ov;
    plain && opc == OPC_DECIMAL_ADJUST |=>
      flags_o.overflow_flag == $past(flags_i.overflow_flag);
  endproperty
  a_da_ov: assert property (p_da_ov)
    else $error("decimal adjust changed overflow");
  property p_dec_acc;
    plain && opc == OPC_DEC_ACC |=> result_o[7:0] == $past(acc_i) - 8'h01;
  endproperty
  a_dec_acc: assert property (p_dec_acc)
    else $error("decrement result wrong");
  property p_cpl_bit;
    plain && opc == OPC_CPL_BIT |=> wr_bit_o && flags_o == $past(flags_i);
  endproperty
  a_cpl_bit: assert property (p_cpl_bit)
    else $error("bit complement changed flags");
  property p_ill;
    illegal_o |-> !wr_acc_o && !wr_bit_o && flags_o == $past(flags_i);
  endproperty
  a_ill: assert property (p_ill)
    else $error("refused request wrote state");
endmodule // cbd_alu_monitor
bind cbd_alu cbd_alu_monitor #(.DATA_W(DATA_W)) i_cbd_alu_monitor (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .exec_i(exec_i), .instr_i(instr_i), .acc_i(acc_i), .flags_i(flags_i),
  .flags_o(flags_o), .result_o(result_o), .wr_acc_o(wr_acc_o),
  .wr_bit_o(wr_bit_o), .illegal_o(illegal_o));
`default_nettype wire

// >>> tb/test_complement_bcd_decrement_alu.sv
`timescale 1ns/100ps
`default_nettype none
module test_complement_bcd_decrement_alu;
  import cbd_alu_pkg::*;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, exec_i = 1'b0;
  logic source_mode_i = 1'b0, short_wide_i = 1'b0, mem_is_port_i = 1'b0;
  logic bit_val_i = 1'b0, bit_is_port_i = 1'b0, bit_latch_i = 1'b0;
  logic [7:0] acc_i = 8'h00, mem_byte_i = 8'h00, port_latch_i = 8'h00;
  logic [31:0] reg_val_i = 32'h0, result_o;
  instr_t instr_i = '0;
  flags_t flags_i = '0, flags_o;
  logic [2:0] bit_pos_o;
  logic [7:0] addr_o;
  logic wr_acc_o, wr_mem_o, wr_reg_o, wr_bit_o, illegal_o;
  op_width_t width_o;
  int n_mismatch = 0, compares = 0, cycles = 0;
  cbd_alu i_cbd_alu (.sys_clk_i, .sys_rst_i, .clk_en_i, .exec_i,
    .source_mode_i, .instr_i, .short_wide_i, .acc_i, .mem_byte_i,
    .mem_is_port_i, .port_latch_i, .bit_val_i, .bit_is_port_i, .bit_latch_i,
    .reg_val_i, .flags_i, .flags_o, .result_o, .bit_pos_o, .addr_o,
    .wr_acc_o, .wr_mem_o, .wr_reg_o, .wr_bit_o, .width_o, .illegal_o);
  ////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard well above the run length
  initial forever #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // One request, result readable when the task returns
  task automatic exe(input logic e, input logic [7:0] op,
                     input logic [7:0] od);
    @(posedge sys_clk_i);
    #1 exec_i = 1'b1;
    instr_i = '{e, op, od};
    @(posedge sys_clk_i);
    #1 exec_i = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cpl();
    flags_i = 5'h1C;
    acc_i = 8'h5C;
    exe(1'b0, OPC_CPL_ACC, 8'h00);
    chk({wr_acc_o, flags_o, result_o[7:0]}, 14'h3EA3);
    source_mode_i = 1'b1;
    exe(1'b0, OPC_CPL_ACC, 8'h00);
    chk({wr_acc_o, flags_o, result_o[7:0]}, 14'h3EA3);
    exe(1'b1, OPC_CPL_ACC, 8'h00);
    chk({illegal_o, wr_acc_o, flags_o}, 7'h5C);
    $display("test cpl done");
  endtask
  // Columns: input, carry/aux in, carry out and result
  task automatic t_da();
    logic [7:0] da_in[4] = '{8'hBE, 8'hC9, 8'h09, 8'h9A};
    logic [1:0] da_fl[4] = '{2'h2, 2'h0, 2'h1, 2'h0};
    logic [8:0] da_out[4] = '{9'h124, 9'h129, 9'h00F, 9'h100};
    for (int i = 0; i < 4; i++) begin
      acc_i = da_in[i];
      flags_i = {da_fl[i], 3'h4};
      exe(1'b0, OPC_DECIMAL_ADJUST, 8'h00);
      chk(result_o[7:0], da_out[i][7:0]);
      chk({flags_o[4], flags_o[2]}, {da_out[i][8], 1'b1});
    end
    $display("test da done");
  endtask
  // Port operand must come from the latch, not the pins
  task automatic t_dec();
    logic [7:0] ops[3] = '{8'h17, 8'h1F, OPC_DEC_SHORT};
    flags_i = 5'h1C;
    acc_i = 8'h00;
    mem_byte_i = 8'h01;
    exe(1'b0, OPC_DEC_ACC, 8'h00);
    chk({wr_acc_o, flags_o, result_o[7:0]}, 14'h3EFF);
    // Enable low: the request is ignored and every output holds
    clk_en_i = 1'b0;
    acc_i = 8'h3C;
    exe(1'b0, OPC_CPL_ACC, 8'h00);
    chk({wr_acc_o, flags_o, result_o[7:0]}, 14'h3EFF);
    clk_en_i = 1'b1;
    exe(1'b0, OPC_DEC_DIR, 8'h40);
    chk({wr_mem_o, flags_o, result_o[7:0], addr_o}, 22'h3D0040);
    mem_is_port_i = 1'b1;
    mem_byte_i = 8'h55;
    port_latch_i = 8'h10;
    exe(1'b0, OPC_DEC_DIR, 8'h90);
    chk({wr_mem_o, flags_o, result_o[7:0]}, 14'h3C0F);
    for (int i = 0; i < 12; i++) begin
      source_mode_i = i[0];
      exe(i[1], ops[i / 4], 8'h34);
      // 1B is also a register form, so the short strobe tells them apart
      chk(i / 4 == 2 ? wr_reg_o : illegal_o, i[1] != i[0]);
    end
    $display("test dec done");
  endtask
  task automatic t_short();
    logic [7:0] od[4] = '{8'h35, 8'h36, 8'h3C, 8'h3E};
    logic [31:0] rv[4] = '{32'h10, 32'h10001, 32'h1, 32'h3};
    logic [31:0] res[4] = '{32'hE, 32'hFFFD, 32'h0, 32'hFFFFFFFF};
    logic [4:0] fl[4] = '{5'h1C, 5'h1E, 5'h1D, 5'h1E};
    op_width_t wd[4] = '{WIDTH_BYTE, WIDTH_WORD, WIDTH_DWORD, WIDTH_DWORD};
    source_mode_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      short_wide_i = (i == 1);
      reg_val_i = rv[i];
      exe(1'b1, OPC_DEC_SHORT, od[i]);
      chk(result_o, res[i]);
      chk({wr_reg_o, width_o, flags_o}, {1'b1, wd[i], fl[i]});
    end
    exe(1'b1, OPC_DEC_SHORT, 8'h37);
    chk({illegal_o, wr_reg_o}, 2'h2);
    $display("test short done");
  endtask
  task automatic t_bit();
    flags_i = 5'h00;
    bit_val_i = 1'b1;
    exe(1'b0, OPC_CPL_BIT, 8'h20);
    chk({wr_bit_o, result_o[0], flags_o, addr_o}, 15'h4020);
    bit_is_port_i = 1'b1;
    exe(1'b0, OPC_CPL_BIT, 8'h90);
    chk({wr_bit_o, result_o[0]}, 2'h3);
    flags_i = 5'h1B;
    exe(1'b0, OPC_CPL_CARRY, 8'h00);
    chk({wr_bit_o, flags_o}, 6'h0B);
    bit_is_port_i = 1'b0;
    bit_val_i = 1'b0;
    exe(1'b1, OPC_EXT_BIT, 8'hB5);
    chk({wr_bit_o, result_o[0], bit_pos_o, flags_o}, 10'h3BB);
    exe(1'b0, OPC_EXT_BIT, 8'hB5);
    chk({illegal_o, wr_bit_o}, 2'h2);
    $display("test bit done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1 sys_rst_i = 1'b0;
    chk({illegal_o, wr_acc_o, flags_o}, 7'h00);
    t_cpl();
    t_da();
    t_dec();
    t_short();
    t_bit();
    end_of_test();
  end
endmodule // test_complement_bcd_decrement_alu
`default_nettype wire
